/* dv/ext_trigger_source.sv */
// Partner model: external trigger and gate source on one line
`timescale 1ns/10ps
`default_nettype none
module ext_trigger_source (
  input  wire logic mclk_in,
  input  wire logic level_req_in,
  output var  logic line_out
);
  initial line_out = 1'b0;
  // Edges and gate level share this one line
  always @(posedge mclk_in) line_out <= level_req_in;
endmodule
`default_nettype wire

/* dv/test_pulse_train_sequencer.sv */
// Self-checking bench for the pulse train sequencer
`timescale 1ns/10ps
`default_nettype none
`include "train_consts.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module test_pulse_train_sequencer import train_pkg::*; ;
  typedef struct {logic [1:0] sel; int n; logic [`ADDR_W-1:0] exp;} load_row_t;
  logic               mclk_in = 1'b0;
  logic               reset_in = 1'b1;
  logic               train_playback_mode_in = 1'b1;
  trig_mode_t         trig_mode_in = TRIG_SINGLE;
  logic               slope_falling_in = 1'b0;
  logic               gate_inverted_in = 1'b0;
  logic               single_cmd_in = 1'b0;
  logic               level_req = 1'b0;
  logic               external_pulse_input;
  logic               load_start_in = 1'b0;
  logic               load_valid_in = 1'b0;
  logic [1:0]         load_list_in = 2'h0;
  logic [`TIME_W-1:0] load_data_in = '0;
  logic               pulse_out;
  logic               running_out;
  logic [`ADDR_W-1:0] on_count_out, off_count_out, rep_count_out;
  int                 n_mismatch = 0;
  int                 check_count = 0;
  int                 highs, rises;
  // Replacement and the depth limit both show in the counts
  load_row_t rows [6] = '{'{`LIST_SEL_ON, 5, 11'h005}, '{`LIST_SEL_ON, 2, 11'h002},
    '{`LIST_SEL_ON, 2050, 11'h7FF}, '{`LIST_SEL_OFF, 3, 11'h003},
    '{`LIST_SEL_REP, 4, 11'h004}, '{`LIST_SEL_ON, 3, 11'h003}};

  always #10 mclk_in = ~mclk_in;

  ext_trigger_source ext_trigger_source_i (.mclk_in(mclk_in), .level_req_in(level_req),
    .line_out(external_pulse_input));

  pulse_train_sequencer pulse_train_sequencer_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .train_playback_mode_in(train_playback_mode_in), .trig_mode_in(trig_mode_in),
    .slope_falling_in(slope_falling_in), .gate_inverted_in(gate_inverted_in),
    .external_pulse_input(external_pulse_input), .single_cmd_in(single_cmd_in),
    .load_start_in(load_start_in), .load_list_in(load_list_in),
    .load_valid_in(load_valid_in), .load_data_in(load_data_in), .pulse_out(pulse_out),
    .running_out(running_out), .on_count_out(on_count_out),
    .off_count_out(off_count_out), .rep_count_out(rep_count_out));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [`ADDR_W-1:0] pick_count(input logic [1:0] sel);
    return (sel == `LIST_SEL_ON) ? on_count_out :
           (sel == `LIST_SEL_OFF) ? off_count_out : rep_count_out;
  endfunction

  // Reps 2,0,1,5: the zero pair is skipped, the fourth lies past the shortest list
  // Times arrive already turned from the supplier's doubles into cycles
  task automatic load_list(input logic [1:0] sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in);
      load_list_in <= sel;
      load_start_in <= 1'(i == 0);
      load_valid_in <= 1'b1;
      load_data_in <= (sel == `LIST_SEL_ON) ? 32'h3 : (sel == `LIST_SEL_OFF) ? 32'h2 :
                      (i == 0) ? 32'h2 : (i == 1) ? 32'h0 : (i == 2) ? 32'h1 : 32'h5;
    end
    @(posedge mclk_in);
    load_start_in <= 1'b0;
    load_valid_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask

  task automatic measure(input int n);
    logic prev;
    highs = 0;
    rises = 0;
    @(posedge mclk_in);
    #1;
    prev = pulse_out;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in);
      #1;
      highs += int'(pulse_out === 1'b1);
      rises += int'(pulse_out === 1'b1 && prev !== 1'b1);
      prev = pulse_out;
    end
  endtask

  task automatic step(input trig_mode_t m, input logic s, g, lv, input int n);
    @(posedge mclk_in);
    trig_mode_in <= m;
    slope_falling_in <= s;
    gate_inverted_in <= g;
    level_req <= lv;
    measure(n);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (running_out !== 1'b0 && k < 2000) begin
      @(posedge mclk_in);
      k++;
    end
    if (k == 2000) begin
      n_mismatch++;
      $display("Error at %0t: run never ended", $time);
      tally_and_finish();
    end
  endtask

  initial begin
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    `CHK(on_count_out, 11'h000)
    `CHK(pulse_out, 1'b0)
    foreach (rows[r]) begin
      load_list(rows[r].sel, rows[r].n);
      `CHK(pick_count(rows[r].sel), rows[r].exp)
    end
    @(posedge mclk_in);
    single_cmd_in <= 1'b1;
    @(posedge mclk_in);
    single_cmd_in <= 1'b0;
    measure(100);
    `CHK(highs, 9)
    `CHK(rises, 3)
    wait_idle();
    step(TRIG_EXT, 1'b0, 1'b0, 1'b1, 100);
    `CHK(highs, 9)
    wait_idle();
    step(TRIG_EXT, 1'b1, 1'b0, 1'b0, 100);
    `CHK(rises, 3)
    wait_idle();
    step(TRIG_EXT, 1'b1, 1'b0, 1'b1, 60);
    `CHK(highs, 0)
    step(TRIG_GATED, 1'b0, 1'b0, 1'b1, 100);
    `CHK(highs > 9, 1'b1)
    step(TRIG_GATED, 1'b0, 1'b1, 1'b1, 4);
    step(TRIG_GATED, 1'b0, 1'b1, 1'b1, 60);
    `CHK(highs, 0)
    step(TRIG_GATED, 1'b0, 1'b1, 1'b0, 60);
    `CHK(highs > 0, 1'b1)
    step(TRIG_AUTO, 1'b0, 1'b0, 1'b0, 200);
    `CHK(highs > 9, 1'b1)
    @(posedge mclk_in);
    train_playback_mode_in <= 1'b0;
    wait_idle();
    measure(100);
    `CHK(highs, 0)
    @(posedge mclk_in);
    train_playback_mode_in <= 1'b1;
    // Reset in mid-run must quieten every output
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    `CHK(rep_count_out, 11'h000)
    `CHK({pulse_out, running_out}, 2'h0)
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* hw/pulse_train_sequencer.sv */
// Pulse train sequencer top: list storage and playback
// Summary of operation
// - Store on and off lists, 2047 deep.
// - Report each list count, zero after reset.
// - Each pair has 16-bit repetition count.
// - Zero-count pairs skipped but kept stored.
// - Loading a list replaces whole contents.
// - Reset clears list counts; train selection kept.
// - Play selected train in train mode.
// - Normal gate polarity: pulse while high.
// - Trigger edge selectable, rising after reset.
// - Auto mode runs continuously.
// - External mode starts on active edge.
// - Gated mode pulses only while gate active.
// - Single mode plays sequence once per start.
// - Software single trigger starts one run.
// - Output built from on/off pairs.
`timescale 1ns/10ps
`default_nettype none
`include "train_consts.svh"
module pulse_train_sequencer import train_pkg::*; (
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  input  wire logic                 train_playback_mode_in,
  input  wire trig_mode_t           trig_mode_in,
  input  wire logic                 slope_falling_in,
  input  wire logic                 gate_inverted_in,
  input  wire logic                 external_pulse_input,
  input  wire logic                 single_cmd_in,
  input  wire logic                 load_start_in,
  input  wire logic [1:0]           load_list_in,
  input  wire logic                 load_valid_in,
  input  wire logic [`TIME_W-1:0]   load_data_in,
  output logic                      pulse_out,
  output logic                      running_out,
  output logic [`ADDR_W-1:0]        on_count_out,
  output logic [`ADDR_W-1:0]        off_count_out,
  output logic [`ADDR_W-1:0]        rep_count_out
);
  // Times are cycle counts at 50 MHz; float conversion is upstream
  logic [`TIME_W-1:0] on_mem  [0:`LIST_DEPTH-1];
  logic [`TIME_W-1:0] off_mem [0:`LIST_DEPTH-1];
  logic [`REP_W-1:0]  rep_mem [0:`LIST_DEPTH-1];
  logic [`ADDR_W-1:0] on_cnt_q;
  logic [`ADDR_W-1:0] off_cnt_q;
  logic [`ADDR_W-1:0] rep_cnt_q;
  logic [`ADDR_W-1:0] idx_q;
  logic [`TIME_W-1:0] on_t_q;
  logic [`TIME_W-1:0] off_t_q;
  logic [`REP_W-1:0]  rep_q;
  logic [`REP_W-1:0]  rep_left_q;
  logic [`TIME_W-1:0] tmr_q;
  play_state_t        st_q;
  logic               pulse_q;
  logic               running_q;
  logic               done_q;
  trig_if tif ();
  trig_ctrl u_trig (
    .mclk_in          (mclk_in),
    .reset_in         (reset_in),
    .mode_in          (trig_mode_in),
    .slope_falling_in (slope_falling_in),
    .gate_inverted_in (gate_inverted_in),
    .ext_pulse_in     (external_pulse_input),
    .single_cmd_in    (single_cmd_in),
    .tif              (tif)
  );
  assign tif.run_done = done_q;
  wire sel_on_w  = load_list_in == `LIST_SEL_ON;
  wire sel_off_w = load_list_in == `LIST_SEL_OFF;
  wire sel_rep_w = load_list_in == `LIST_SEL_REP;
  wire [`ADDR_W-1:0] max_w = `ADDR_W'(`LIST_DEPTH);
  // Loading restarts at entry zero, so the old list is discarded
  wire [`ADDR_W-1:0] on_wa_w  = load_start_in ? '0 : on_cnt_q;
  wire [`ADDR_W-1:0] off_wa_w = load_start_in ? '0 : off_cnt_q;
  wire [`ADDR_W-1:0] rep_wa_w = load_start_in ? '0 : rep_cnt_q;
  wire on_we_w  = load_valid_in && sel_on_w  && on_wa_w  != max_w;
  wire off_we_w = load_valid_in && sel_off_w && off_wa_w != max_w;
  wire rep_we_w = load_valid_in && sel_rep_w && rep_wa_w != max_w;
  // Pair count is the shortest of the three lists
  wire [`ADDR_W-1:0] m1_w    = (on_cnt_q < off_cnt_q) ? on_cnt_q : off_cnt_q;
  wire [`ADDR_W-1:0] pairs_w = (m1_w < rep_cnt_q) ? m1_w : rep_cnt_q;
  wire last_w   = (idx_q + `ADDR_W'(1)) >= pairs_w;
  wire active_w = train_playback_mode_in && tif.gate_ok;
  // Memories hold no reset, but reset clears the counts, so stored trains are not played after it
  always_ff @(posedge mclk_in) begin
    if (on_we_w)
      on_mem[on_wa_w] <= load_data_in;
    if (off_we_w)
      off_mem[off_wa_w] <= load_data_in;
    if (rep_we_w)
      rep_mem[rep_wa_w] <= load_data_in[`REP_W-1:0];
    on_t_q  <= on_mem[idx_q];
    off_t_q <= off_mem[idx_q];
    rep_q   <= rep_mem[idx_q];
  end
  // Counts are visible state; they clear at reset
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      on_cnt_q  <= '0;
      off_cnt_q <= '0;
      rep_cnt_q <= '0;
    end else begin
      if (load_start_in && sel_on_w)
        on_cnt_q <= on_we_w ? `ADDR_W'(1) : '0;
      else if (on_we_w)
        on_cnt_q <= on_cnt_q + `ADDR_W'(1);
      if (load_start_in && sel_off_w)
        off_cnt_q <= off_we_w ? `ADDR_W'(1) : '0;
      else if (off_we_w)
        off_cnt_q <= off_cnt_q + `ADDR_W'(1);
      if (load_start_in && sel_rep_w)
        rep_cnt_q <= rep_we_w ? `ADDR_W'(1) : '0;
      else if (rep_we_w)
        rep_cnt_q <= rep_cnt_q + `ADDR_W'(1);
    end
  end
  // Playback: fetch, check repetition, on phase, off phase
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q       <= ST_IDLE;
      idx_q      <= '0;
      rep_left_q <= '0;
      tmr_q      <= '0;
      pulse_q    <= 1'b0;
      running_q  <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          pulse_q <= 1'b0;
          // One run per start, which makes single mode play once
          if (tif.start && train_playback_mode_in && pairs_w != '0) begin
            idx_q     <= '0;
            running_q <= 1'b1;
            st_q      <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          st_q <= ST_CHECK;
        end
        ST_CHECK: begin
          if (!train_playback_mode_in) begin
            running_q <= 1'b0;
            st_q      <= ST_IDLE;
          end else if (rep_q == '0) begin
            // Zero count skips the pair without removing it
            if (last_w) begin
              running_q <= 1'b0;
              done_q    <= 1'b1;
              st_q      <= ST_IDLE;
            end else begin
              idx_q <= idx_q + `ADDR_W'(1);
              st_q  <= ST_FETCH;
            end
          end else if (active_w) begin
            // Hold here while the gate is closed, so no pulse leaks out
            rep_left_q <= rep_q;
            tmr_q      <= on_t_q;
            pulse_q    <= on_t_q != '0;
            st_q       <= ST_ON;
          end
        end
        ST_ON: begin
          if (!train_playback_mode_in) begin
            pulse_q   <= 1'b0;
            running_q <= 1'b0;
            st_q      <= ST_IDLE;
          end else if (active_w) begin
            if (tmr_q <= `TIME_W'(1)) begin
              pulse_q <= 1'b0;
              tmr_q   <= off_t_q;
              st_q    <= ST_OFF;
            end else begin
              tmr_q <= tmr_q - `TIME_W'(1);
            end
          end
          // Gate closed: output held low, timing frozen
          if (train_playback_mode_in && !active_w)
            pulse_q <= 1'b0;
          else if (active_w && tmr_q > `TIME_W'(1))
            pulse_q <= 1'b1;
        end
        ST_OFF: begin
          pulse_q <= 1'b0;
          if (!train_playback_mode_in) begin
            running_q <= 1'b0;
            st_q      <= ST_IDLE;
          end else if (active_w) begin
            if (tmr_q <= `TIME_W'(1)) begin
              if (rep_left_q > `REP_W'(1)) begin
                rep_left_q <= rep_left_q - `REP_W'(1);
                tmr_q      <= on_t_q;
                pulse_q    <= on_t_q != '0;
                st_q       <= ST_ON;
              end else if (last_w) begin
                running_q <= 1'b0;
                done_q    <= 1'b1;
                st_q      <= ST_IDLE;
              end else begin
                idx_q <= idx_q + `ADDR_W'(1);
                st_q  <= ST_FETCH;
              end
            end else begin
              tmr_q <= tmr_q - `TIME_W'(1);
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pulse_out     <= 1'b0;
      running_out   <= 1'b0;
      on_count_out  <= '0;
      off_count_out <= '0;
      rep_count_out <= '0;
    end else begin
      pulse_out     <= pulse_q;
      running_out   <= running_q;
      on_count_out  <= on_cnt_q;
      off_count_out <= off_cnt_q;
      rep_count_out <= rep_cnt_q;
    end
  end
  a_zero_skip: assert property (@(posedge mclk_in) disable iff (reset_in)
    (st_q == ST_CHECK && rep_q == '0) |=> st_q != ST_ON)
    else $error("zero repetition pair was played");
  a_count_max: assert property (@(posedge mclk_in) disable iff (reset_in)
    (load_valid_in && sel_on_w && !load_start_in && on_cnt_q == max_w) |=> on_cnt_q == max_w)
    else $error("list count above depth");
  a_reload_clear: assert property (@(posedge mclk_in) disable iff (reset_in)
    (load_start_in && sel_on_w) |=> on_cnt_q == `ADDR_W'($past(load_valid_in)))
    else $error("reload did not clear list");
  a_no_mode_idle: assert property (@(posedge mclk_in) disable iff (reset_in)
    !train_playback_mode_in |=> ##1 !pulse_q)
    else $error("pulse outside train mode");
  a_gate_low: assert property (@(posedge mclk_in) disable iff (reset_in)
    (trig_mode_in == TRIG_GATED && !tif.gate_ok && $stable(trig_mode_in)) |=> !pulse_q)
    else $error("pulse while gate closed");
  a_off_low: assert property (@(posedge mclk_in) disable iff (reset_in)
    st_q == ST_OFF |-> !pulse_q)
    else $error("output high in off phase");
  a_pairs_bound: assert property (@(posedge mclk_in) disable iff (reset_in)
    st_q != ST_IDLE |-> idx_q < pairs_w)
    else $error("index beyond shortest list");
  a_on_high: assert property (@(posedge mclk_in) disable iff (reset_in)
    (st_q == ST_ON && active_w && tmr_q > `TIME_W'(1)) |=> pulse_q)
    else $error("output low inside on phase");
endmodule
`default_nettype wire

/* hw/trig_ctrl.sv */
// Trigger controller: mode, edge and gate qualification
`timescale 1ns/10ps
`default_nettype none
`include "train_consts.svh"
module trig_ctrl import train_pkg::*; (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire trig_mode_t mode_in,
  input  wire logic       slope_falling_in,
  input  wire logic       gate_inverted_in,
  input  wire logic       ext_pulse_in,
  input  wire logic       single_cmd_in,
  trig_if.ctrl            tif
);
  logic ext_q;
  logic armed_q;
  logic start_q;
  wire  rise_w   = ext_pulse_in & ~ext_q;
  wire  fall_w   = ~ext_pulse_in & ext_q;
  // Trigger and gate share the same external pulse input
  wire  edge_w   = slope_falling_in ? fall_w : rise_w;
  wire  gate_w   = gate_inverted_in ? ~ext_pulse_in : ext_pulse_in;
  wire  start_d  = (mode_in == TRIG_EXT) ? edge_w :
                   (mode_in == TRIG_SINGLE) ? single_cmd_in :
                   1'b0;
  // Auto and gated modes keep the sequencer running; gated pauses it
  assign tif.gate_ok = (mode_in == TRIG_GATED) ? gate_w : 1'b1;
  // Two idle cycles after each run mark the train boundary
  assign tif.start   = start_q | (armed_q & ~tif.run_done);
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ext_q   <= 1'b0;
      start_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      ext_q   <= ext_pulse_in;
      start_q <= start_d;
      // Auto and gated: restart after each run ends
      armed_q <= (mode_in == TRIG_AUTO) || (mode_in == TRIG_GATED);
    end
  end
endmodule
`default_nettype wire

/* inc/train_consts.svh */
// Constants for the pulse train sequencer
`ifndef TRAIN_CONSTS_SVH
`define TRAIN_CONSTS_SVH
`define LIST_DEPTH      2047
`define ADDR_W          11
`define TIME_W          32
`define REP_W           16
`define LIST_SEL_ON     2'h0
`define LIST_SEL_OFF    2'h1
`define LIST_SEL_REP    2'h2
`endif

/* inc/train_pkg.sv */
// Types for the pulse train sequencer
package train_pkg;
  typedef enum logic [1:0] {
    TRIG_AUTO   = 2'h0,
    TRIG_EXT    = 2'h1,
    TRIG_GATED  = 2'h2,
    TRIG_SINGLE = 2'h3
  } trig_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_CHECK = 3'h2,
    ST_ON    = 3'h3,
    ST_OFF   = 3'h4
  } play_state_t;
endpackage

/* inc/trig_if.sv */
// Trigger controller to sequencer handshake
`timescale 1ns/10ps
`default_nettype none
interface trig_if;
  logic start;
  logic gate_ok;
  logic run_done;
  modport ctrl (output start, output gate_ok, input run_done);
  modport seq  (input start, input gate_ok, output run_done);
endinterface
`default_nettype wire
